// >>> stx_consts.svh
`ifndef STX_CONSTS_SVH
`define STX_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define STX_OFF_UNLOCK_FIRST 32'hffff0880
`define STX_OFF_CONTROL 32'hffff0884
`define STX_OFF_UNLOCK_LAST 32'hffff0888
`define STX_OFF_BYTES_ONE_TWO 32'hffff088c
`define STX_OFF_BYTES_THREE_FOUR 32'hffff0890
`define STX_OFF_BYTES_FIVE_SIX 32'hffff0894
// ----------------------------------------------------------------
// Key values and field positions
// ----------------------------------------------------------------
`define STX_KEY_FIRST 16'h0007
`define STX_KEY_LAST 16'h00b9
`define STX_CTL_ENABLE 0
`define STX_CTL_RESET 1
`define STX_CTL_COUNT_LO 2
`define STX_CTL_COUNT_HI 4
`define STX_CTL_STATE_LO 5
`define STX_CTL_STATE_HI 8
`define STX_CTL_RESET_VAL 16'h0000
`define STX_DAT_RESET_VAL 16'h0000
// ----------------------------------------------------------------
// Packet shape
// ----------------------------------------------------------------
`define STX_PACKET_BITS 4'hc
`define STX_MAX_BYTES 3'h6
`endif

// >>> stx_pkg.sv
package stx_pkg;
  // Key sequence tracker
  typedef enum logic [2:0] {
    STX_KEY_IDLE = 3'b001,
    STX_KEY_ARMED = 3'b010,
    STX_KEY_PENDING = 3'b100
  } stx_key_state_t;
  // Transmit sequencer
  typedef enum logic [2:0] {
    STX_TX_IDLE = 3'b001,
    STX_TX_WAIT = 3'b010,
    STX_TX_SEND = 3'b100
  } stx_tx_state_t;
  // Register bus request
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } stx_req_t;
endpackage

// >>> stx_rx_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Diagnostic receiver on the test line
// ----------------------------------------------------------------
module stx_rx_model (
  input wire logic clk,
  input wire logic baudTick,
  input wire logic serialOut,
  output int nRx,
  output int nBad,
  output logic [47:0] rxBytes
);
  logic [11:0] frameBits;
  int bitCnt;
  // Counters start clear
  initial begin
    nRx = 0;
    nBad = 0;
    bitCnt = 0;
    rxBytes = '0;
  end
  // One sample per tick: the bit launched at the previous tick
  always @(posedge clk) begin
    if (baudTick && (bitCnt > 0 || serialOut === 1'b0)) begin
      frameBits[bitCnt] = serialOut;
      bitCnt = bitCnt + 1;
    end
    if (bitCnt == 12) begin
      bitCnt = 0;
      nRx = nRx + 1;
      rxBytes = {rxBytes[39:0], frameBits[8:1]};
      if (frameBits[0] !== 1'b0 || frameBits[9] !== ^frameBits[8:1]
          || frameBits[11:10] !== 2'b11) begin
        nBad = nBad + 1;
      end
    end
  end
endmodule // stx_rx_model

// >>> stx_serial_test_transmitter.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "stx_consts.svh"
// Functional notes
// [RQ1] Send one to six 12-bit packets
// [RQ2] Start, eight data, even parity, two stops
// [RQ3] Each bit period is one baud tick
// [RQ4] Software writes first key before control
// [RQ5] Software writes last key after control
// [RQ6] Control write without first key ignored
// [RQ7] Control write dropped without last key
// [RQ8] Bytes one, two readable and writable
// [RQ9] Bytes three, four from second register
// [RQ10] Bytes five, six from third register
// [RQ11] Count field: code plus one bytes
// [RQ12] State bits nonzero while transmitting
// [RQ13] Reset bit clears whole interface
// [RQ14] Bit zero enables the interface
// [RQ15] Enabled interface starts without command
// [RQ16] Software writes reserved bits as zero
// [RQ17] Software selects pin function first
// [RQ18] Wait until counted bytes are written
// [RQ19] LSB first, ascending bytes, idle high
// [RQ20] Start bit low, opposite idle
module stx_serial_test_transmitter #(
  parameter int DATA_REGS = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire stx_pkg::stx_req_t busReq,
  output logic [15:0] busRdata,
  input wire logic baudTick,
  output logic serialOut
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hitKeyFirst = busReq.addr == `STX_OFF_UNLOCK_FIRST;
  wire hitControl = busReq.addr == `STX_OFF_CONTROL;
  wire hitKeyLast = busReq.addr == `STX_OFF_UNLOCK_LAST;
  wire [DATA_REGS-1:0] hitData;
  assign hitData[0] = busReq.addr == `STX_OFF_BYTES_ONE_TWO;
  assign hitData[1] = busReq.addr == `STX_OFF_BYTES_THREE_FOUR;
  assign hitData[2] = busReq.addr == `STX_OFF_BYTES_FIVE_SIX;
  wire anyAccess = busReq.wr | busReq.rd;
  wire keyFirstOk = busReq.wr & hitKeyFirst & (busReq.wdata == `STX_KEY_FIRST);
  wire keyLastOk = busReq.wr & hitKeyLast & (busReq.wdata == `STX_KEY_LAST);

  // ----------------------------------------------------------------
  // Key sequence
  // ----------------------------------------------------------------
  stx_pkg::stx_key_state_t keyState_reg, keyState_next;
  logic [15:0] pendCtl_reg, pendCtl_next;
  logic [15:0] ctlStored_reg;
  logic commitCtl;

  // Any other access between the steps breaks the sequence; a repeated first key after the first key keeps it armed
  always_comb begin
    keyState_next = keyState_reg;
    pendCtl_next = pendCtl_reg;
    commitCtl = 1'b0;
    if (anyAccess) begin
      unique case (keyState_reg)
        stx_pkg::STX_KEY_IDLE: begin
          if (keyFirstOk) keyState_next = stx_pkg::STX_KEY_ARMED;
        end
        stx_pkg::STX_KEY_ARMED: begin
          if (busReq.wr && hitControl) begin // RQ6
            keyState_next = stx_pkg::STX_KEY_PENDING;
            pendCtl_next = busReq.wdata;
          end else if (keyFirstOk) begin
            keyState_next = stx_pkg::STX_KEY_ARMED;
          end else begin
            keyState_next = stx_pkg::STX_KEY_IDLE; // RQ6
          end
        end
        stx_pkg::STX_KEY_PENDING: begin
          commitCtl = keyLastOk; // RQ7
          keyState_next = keyFirstOk ? stx_pkg::STX_KEY_ARMED : stx_pkg::STX_KEY_IDLE;
        end
        default: keyState_next = stx_pkg::STX_KEY_IDLE;
      endcase
    end
  end

  wire ctlResetReq = commitCtl & pendCtl_reg[`STX_CTL_RESET]; // RQ13
  wire softClear = ~resetn | ctlResetReq;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      keyState_reg <= stx_pkg::STX_KEY_IDLE;
      pendCtl_reg <= `STX_CTL_RESET_VAL;
    end else begin
      keyState_reg <= keyState_next;
      pendCtl_reg <= pendCtl_next;
    end
  end

  // Stored control: enable and count only; reserved and state bits dropped
  always_ff @(posedge clk) begin
    if (softClear) begin
      ctlStored_reg <= `STX_CTL_RESET_VAL; // RQ13
    end else if (commitCtl) begin
      ctlStored_reg <= {11'h000, pendCtl_reg[`STX_CTL_COUNT_HI:`STX_CTL_COUNT_LO], 1'b0,
                        pendCtl_reg[`STX_CTL_ENABLE]}; // RQ14
    end
  end

  wire ctlEnable = ctlStored_reg[`STX_CTL_ENABLE]; // RQ14
  wire [2:0] countCode = ctlStored_reg[`STX_CTL_COUNT_HI:`STX_CTL_COUNT_LO];
  // Codes above six bytes clamp to six
  wire [2:0] byteTotal = (countCode >= 3'h5) ? `STX_MAX_BYTES : countCode + 3'h1; // RQ11

  // ----------------------------------------------------------------
  // Data registers and written-byte tracking
  // ----------------------------------------------------------------
  logic [15:0] dataReg_reg [DATA_REGS];
  logic [2*DATA_REGS-1:0] byteLoaded_reg;
  logic txDone;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_REGS; gi++) begin : gData
      always_ff @(posedge clk) begin
        if (softClear) begin
          dataReg_reg[gi] <= `STX_DAT_RESET_VAL;
        end else if (busReq.wr && hitData[gi]) begin
          dataReg_reg[gi] <= busReq.wdata; // RQ8 RQ9 RQ10
        end
      end
      // A write loads both bytes of the register; a finished run releases them,
      // but a write in the run-end cycle wins so fresh data is not lost
      always_ff @(posedge clk) begin
        if (softClear) begin
          byteLoaded_reg[2*gi+1:2*gi] <= 2'b00;
        end else if (busReq.wr && hitData[gi]) begin
          byteLoaded_reg[2*gi+1:2*gi] <= 2'b11; // RQ18
        end else if (txDone) begin
          byteLoaded_reg[2*gi+1:2*gi] <= 2'b00;
        end
      end
    end
  endgenerate

  // Bytes needed: lowest byteTotal bits set
  wire [5:0] needMask = 6'(( 7'h01 << byteTotal) - 7'h01);
  wire allLoaded = (byteLoaded_reg & needMask) == needMask; // RQ18

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  stx_pkg::stx_tx_state_t txState_reg, txState_next;
  logic [3:0] bitIdx_reg, bitIdx_next;
  logic [2:0] byteIdx_reg, byteIdx_next;
  logic [11:0] shift_reg, shift_next;
  logic serialOut_reg, serialOut_next;

  // Byte to load next, taken from registered state so the sequencer has no loop
  wire [2:0] loadIdx = (txState_reg == stx_pkg::STX_TX_SEND) ? byteIdx_reg + 3'h1 : 3'h0;
  wire [7:0] curByte = loadIdx[0] ? dataReg_reg[loadIdx[2:1]][15:8] :
                                    dataReg_reg[loadIdx[2:1]][7:0];
  // Packet, MSB first: stop, stop, parity, data[7:0], start
  wire [11:0] packet = {2'b11, ^curByte, curByte, 1'b0}; // RQ2 RQ19 RQ20

  always_comb begin
    txState_next = txState_reg;
    bitIdx_next = bitIdx_reg;
    byteIdx_next = byteIdx_reg;
    shift_next = shift_reg;
    serialOut_next = serialOut_reg;
    txDone = 1'b0;
    unique case (txState_reg)
      stx_pkg::STX_TX_IDLE: begin
        serialOut_next = 1'b1; // RQ19
        byteIdx_next = 3'h0;
        if (ctlEnable && allLoaded) begin // RQ15 RQ18
          txState_next = stx_pkg::STX_TX_WAIT;
        end
      end
      stx_pkg::STX_TX_WAIT: begin
        // Align the first bit to a tick edge
        if (baudTick) begin // RQ3
          shift_next = {1'b1, packet[11:1]};
          serialOut_next = packet[0];
          bitIdx_next = 4'h1;
          txState_next = stx_pkg::STX_TX_SEND;
        end
      end
      stx_pkg::STX_TX_SEND: begin
        if (baudTick) begin // RQ3
          if (bitIdx_reg == `STX_PACKET_BITS) begin // RQ1
            if (byteIdx_reg + 3'h1 == byteTotal) begin
              txDone = 1'b1;
              serialOut_next = 1'b1;
              txState_next = stx_pkg::STX_TX_IDLE;
            end else begin
              byteIdx_next = byteIdx_reg + 3'h1; // RQ19
              shift_next = {1'b1, packet[11:1]};
              serialOut_next = packet[0];
              bitIdx_next = 4'h1;
            end
          end else begin
            serialOut_next = shift_reg[0];
            shift_next = {1'b1, shift_reg[11:1]};
            bitIdx_next = bitIdx_reg + 4'h1;
          end
        end
      end
      default: txState_next = stx_pkg::STX_TX_IDLE;
    endcase
    if (!ctlEnable) begin
      txState_next = stx_pkg::STX_TX_IDLE; // RQ14
      serialOut_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (softClear) begin
      txState_reg <= stx_pkg::STX_TX_IDLE;
      bitIdx_reg <= 4'h0;
      byteIdx_reg <= 3'h0;
      shift_reg <= 12'hfff;
      serialOut_reg <= 1'b1;
    end else begin
      txState_reg <= txState_next;
      bitIdx_reg <= bitIdx_next;
      byteIdx_reg <= byteIdx_next;
      shift_reg <= shift_next;
      serialOut_reg <= serialOut_next;
    end
  end

  assign serialOut = serialOut_reg;

  // ----------------------------------------------------------------
  // Status and read back
  // ----------------------------------------------------------------
  wire sending = txState_reg == stx_pkg::STX_TX_SEND;
  // Bits 8..5: packet bit position plus one, nonzero while sending
  wire [3:0] stateBits = sending ? bitIdx_reg : 4'h0; // RQ12
  wire [15:0] ctlView = {7'h00, stateBits, ctlStored_reg[4:0]};
  wire [15:0] rdSel = hitControl ? ctlView :
                      hitData[0] ? dataReg_reg[0] :
                      hitData[1] ? dataReg_reg[1] :
                      hitData[2] ? dataReg_reg[2] : 16'h0000;

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busRdata <= 16'h0000;
    end else begin
      busRdata <= busReq.rd ? rdSel : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_START_LOW: assert property (@(posedge clk) disable iff (!resetn) // RQ20
    $rose(sending) |-> !serialOut) else $error("start bit not low");
  AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (!resetn) // RQ19
    (txState_reg == stx_pkg::STX_TX_IDLE) |-> serialOut) else $error("line not idle high");
  AST_NO_KEY: assert property (@(posedge clk) disable iff (!resetn) // RQ6
    (busReq.wr && hitControl && keyState_reg != stx_pkg::STX_KEY_ARMED) |=>
      keyState_reg == stx_pkg::STX_KEY_IDLE) else $error("unkeyed control write kept");
  AST_COMMIT: assert property (@(posedge clk) disable iff (!resetn) // RQ7
    $changed(ctlStored_reg) |-> $past(keyState_reg) == stx_pkg::STX_KEY_PENDING
      && $past(keyLastOk) || $past(ctlResetReq)) else $error("control changed unkeyed");
  AST_STATE_BITS: assert property (@(posedge clk) disable iff (!resetn) // RQ12
    sending |-> stateBits != 4'h0) else $error("state bits zero while sending");
  AST_TICK_ONLY: assert property (@(posedge clk) disable iff (!resetn) // RQ3
    (sending && !baudTick && ctlEnable && $past(sending)) |=> $stable(serialOut))
    else $error("line moved without tick");
  AST_HOLD_OFF: assert property (@(posedge clk) disable iff (!resetn) // RQ18
    (txState_reg == stx_pkg::STX_TX_IDLE && !allLoaded) |=>
      txState_reg == stx_pkg::STX_TX_IDLE) else $error("started before data written");
  AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (!resetn) // RQ13
    ctlResetReq |=> ctlStored_reg == 16'h0000 && !sending) else $error("reset bit ignored");
  AST_DISABLE: assert property (@(posedge clk) disable iff (!resetn) // RQ14
    !ctlEnable |=> txState_reg == stx_pkg::STX_TX_IDLE) else $error("sending while disabled");
  AST_PACKET_LEN: assert property (@(posedge clk) disable iff (!resetn) // RQ1
    sending |-> bitIdx_reg <= `STX_PACKET_BITS && bitIdx_reg != 4'h0) else $error("bad bit index");

  // Framing: both stop bits high, bit position moves only on a tick
  AST_STOP_HIGH: assert property (@(posedge clk) disable iff (!resetn) // RQ2
    (sending && bitIdx_reg >= 4'hb) |-> serialOut) else $error("stop bit not high");
  AST_BIT_HOLD: assert property (@(posedge clk) disable iff (!resetn) // RQ3
    (sending && !baudTick && ctlEnable && !ctlResetReq) |=> $stable(bitIdx_reg))
    else $error("bit position moved without tick");
  // Every run opens with byte one
  AST_FIRST_BYTE: assert property (@(posedge clk) disable iff (!resetn) // RQ19
    $rose(sending) |-> byteIdx_reg == 3'h0) else $error("run not started at byte one");
  // A pending value without the closing key never reaches the control register
  AST_LAST_KEY: assert property (@(posedge clk) disable iff (!resetn) // RQ7
    (keyState_reg == stx_pkg::STX_KEY_PENDING && anyAccess && !keyLastOk) |=>
      $stable(ctlStored_reg)) else $error("control taken without last key");
  // Read data shows only in the cycle after a read strobe
  AST_RD_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    !$past(busReq.rd) |-> busRdata == 16'h0000) else $error("read data outside its cycle");

endmodule // stx_serial_test_transmitter

// >>> stx_serial_test_transmitter_tb_top.sv
`timescale 1ns/1ns
`include "stx_consts.svh"
module stx_serial_test_transmitter_tb_top;
  localparam int BAUD = 5;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic baudTick = 1'b0;
  stx_pkg::stx_req_t busReq = '0;
  logic [15:0] busRdata;
  logic serialOut;
  int nRx;
  int nBad;
  logic [47:0] rxBytes;
  int tickCnt = 0;
  int n_mismatch = 0;
  int compares = 0;

  stx_serial_test_transmitter i_stx_serial_test_transmitter (.clk(clk), .resetn(resetn),
    .busReq(busReq), .busRdata(busRdata), .baudTick(baudTick), .serialOut(serialOut));
  stx_rx_model i_stx_rx_model (.clk(clk), .baudTick(baudTick), .serialOut(serialOut),
    .nRx(nRx), .nBad(nBad), .rxBytes(rxBytes));

  // Clock and baud timer overflow
  always #5 clk = ~clk;
  always @(posedge clk) begin
    tickCnt <= (tickCnt == BAUD - 1) ? 0 : tickCnt + 1;
    baudTick <= (tickCnt == BAUD - 1);
  end
  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic [15:0] d, input logic w, input logic r);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [15:0] exp);
    bus(a, 16'h0000, 1'b0, 1'b1);
    bus(32'h0, 16'h0000, 1'b0, 1'b0);
    #1 chk(busRdata, exp);
  endtask
  task automatic ctl(input logic [15:0] k0, input logic [15:0] v, input logic [15:0] k1);
    bus(`STX_OFF_UNLOCK_FIRST, k0, 1'b1, 1'b0);
    bus(`STX_OFF_CONTROL, v, 1'b1, 1'b0);
    bus(`STX_OFF_UNLOCK_LAST, k1, 1'b1, 1'b0);
    bus(32'h0, 16'h0000, 1'b0, 1'b0);
    @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_resetvals();
    for (int i = 0; i < 7; i++) rdchk(`STX_OFF_UNLOCK_FIRST + 32'(4 * i), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      bus(`STX_OFF_BYTES_ONE_TWO + 32'(4 * i), 16'hbe00 + 16'(i), 1'b1, 1'b0);
    end
    for (int i = 0; i < 3; i++) rdchk(`STX_OFF_BYTES_ONE_TWO + 32'(4 * i), 16'hbe00 + 16'(i));
  endtask
  task automatic t_softreset();
    ctl(16'h0007, 16'h0014, 16'h00b9);
    rdchk(`STX_OFF_CONTROL, 16'h0014);
    bus(`STX_OFF_BYTES_ONE_TWO, 16'h1234, 1'b1, 1'b0);
    ctl(16'h0007, 16'h0016, 16'h00b9);
    rdchk(`STX_OFF_CONTROL, 16'h0000);
    rdchk(`STX_OFF_BYTES_ONE_TWO, 16'h0000);
  endtask
  task automatic t_lock();
    ctl(16'h0006, 16'h0014, 16'h00b9);
    rdchk(`STX_OFF_CONTROL, 16'h0000);
    ctl(16'h0007, 16'h0014, 16'h0009);
    rdchk(`STX_OFF_CONTROL, 16'h0000);
    bus(`STX_OFF_UNLOCK_FIRST, 16'h0007, 1'b1, 1'b0);
    bus(`STX_OFF_BYTES_ONE_TWO, 16'h0000, 1'b0, 1'b1);
    ctl(16'h0000, 16'h0014, 16'h00b9);
    rdchk(`STX_OFF_CONTROL, 16'h0000);
    bus(`STX_OFF_UNLOCK_FIRST, 16'h0007, 1'b1, 1'b0);
    bus(`STX_OFF_CONTROL, 16'h0014, 1'b1, 1'b0);
    rdchk(`STX_OFF_UNLOCK_LAST, 16'h0000);
    rdchk(`STX_OFF_CONTROL, 16'h0000);
    ctl(16'h0007, 16'h0014, 16'h00b9);
    rdchk(`STX_OFF_CONTROL, 16'h0014);
  endtask
  task automatic t_send(input int code);
    logic [15:0] w [3];
    int n0;
    int nb;
    nb = code + 1;
    for (int i = 0; i < 3; i++) w[i] = 16'h1e2d + 16'(i * 15178 + code * 257);
    n0 = nRx;
    ctl(16'h0007, 16'(code << 2) | 16'h0001, 16'h00b9);
    // All but the last needed register written: still no transmission
    for (int i = 0; i < code / 2; i++) begin
      bus(`STX_OFF_BYTES_ONE_TWO + 32'(4 * i), w[i], 1'b1, 1'b0);
    end
    bus(32'h0, 16'h0000, 1'b0, 1'b0);
    repeat (4 * BAUD) @(posedge clk);
    chk(16'(nRx - n0), 16'h0000);
    #1 chk({15'h0, serialOut}, 16'h0001);
    bus(`STX_OFF_BYTES_ONE_TWO + 32'(4 * (code / 2)), w[code / 2], 1'b1, 1'b0);
    bus(32'h0, 16'h0000, 1'b0, 1'b0);
    repeat (3 * BAUD) @(posedge clk);
    bus(`STX_OFF_CONTROL, 16'h0000, 1'b0, 1'b1);
    bus(32'h0, 16'h0000, 1'b0, 1'b0);
    #1 chk({15'h0, busRdata[8:5] != 4'h0}, 16'h0001);
    for (int i = 0; i < 2000 && nRx < n0 + nb; i++) @(posedge clk);
    chk(16'(nRx - n0), 16'(nb));
    chk(16'(nBad), 16'h0000);
    for (int k = 0; k < nb; k++) begin
      chk(16'(rxBytes[8*(nb-1-k) +: 8]), 16'(w[k/2][8*(k%2) +: 8]));
    end
    rdchk(`STX_OFF_CONTROL, 16'(code << 2) | 16'h0001);
  endtask
  task automatic t_disable();
    ctl(16'h0007, 16'h0015, 16'h00b9);
    for (int i = 0; i < 3; i++) bus(`STX_OFF_BYTES_ONE_TWO + 32'(4 * i), 16'h0000, 1'b1, 1'b0);
    bus(32'h0, 16'h0000, 1'b0, 1'b0);
    repeat (6 * BAUD) @(posedge clk);
    ctl(16'h0007, 16'h0014, 16'h00b9);
    #1 chk({15'h0, serialOut}, 16'h0001);
    rdchk(`STX_OFF_CONTROL, 16'h0014);
  endtask
  // Main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_resetvals();
    t_softreset();
    t_lock();
    for (int c = 0; c < 6; c++) t_send(c);
    t_disable();
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
endmodule // stx_serial_test_transmitter_tb_top
